/* File: verilog/safety_pkg.sv */
// Constants and types of the supervisory safety core
//
// Contract
// - Device only answers as I2C slave
// - Slave address is 0x18 plus programmed field
// - Shutdown after 100 us of over-temperature
// - Thermal event flag set, survives shutdown
// - Shutdown: regulators off, outputs low, immediately
// - Each pin function fixed by 2-bit field
// - Pin 1: hi-Z, output, error monitor
// - Pin 2: output, fault input, sync, monitor
// - Pin 3: output, fault input, error, monitor
// - Per-monitor thresholds passed to comparators
// - Selectable debounce from 5 to 125 us
// - Latched fault flags clear on write one
// - Live status follows present fault
// - Fault status readable and routable to power-good
package safety_pkg;

  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam logic [6:0] TICK_LAST = 7'(CLK_MHZ * TICK_US - 1);
  localparam int THERM_DB_US = 100;
  localparam logic [6:0] THERM_TICKS = 7'(THERM_DB_US / TICK_US);
  localparam int UV_DB_US [4] = '{5, 15, 30, 40};
  localparam int OV_DB_US [4] = '{30, 50, 80, 125};
  localparam logic [6:0] ADDR_BASE = 7'h18;
  localparam int MON_N = 4;

  localparam logic [1:0] P1_HIZ = 2'h0;
  localparam logic [1:0] P1_OUT = 2'h1;
  localparam logic [1:0] P1_ERR = 2'h2;
  localparam logic [1:0] P2_OUT = 2'h0;
  localparam logic [1:0] P2_FLT = 2'h1;
  localparam logic [1:0] P2_SYNC = 2'h2;
  localparam logic [1:0] P2_VMON = 2'h3;
  localparam logic [1:0] P3_OUT = 2'h0;
  localparam logic [1:0] P3_FLT = 2'h1;
  localparam logic [1:0] P3_ERR = 2'h2;
  localparam logic [1:0] P3_VMON = 2'h3;

  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_RUN = 2'b01,
    ST_SHUTDOWN = 2'b10
  } mode_t;

  typedef struct packed {
    logic hit;
    logic [6:0] cnt;
  } dbn_t;

  typedef struct packed {
    logic [3:0] undervolt_threshold_sel;
    logic [3:0] overvolt_threshold_sel;
    logic [1:0] fault_debounce_sel;
    logic [1:0] overvolt_debounce_sel;
  } mon_cfg_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } pin_drv_t;

  typedef struct packed {
    logic error_monitor_in1;
    logic error_monitor_in2;
    logic fault_collect_in1;
    logic fault_collect_in2;
    logic volt_monitor_in3;
    logic volt_monitor_in4;
  } pin_route_t;

  typedef struct packed {
    logic [3:0] uv;
    logic [3:0] ov;
  } mon_bits_t;

  typedef struct packed {
    mode_t mode;
    logic [6:0] div;
    dbn_t over_temp_db;
    dbn_t [3:0] uv_db;
    dbn_t [3:0] ov_db;
    mon_bits_t live;
    mon_bits_t flag;
    logic [3:0] fault;
    logic [5:0] pin_sel;
    mon_cfg_t [3:0] cfg;
    logic [6:0] slave_addr;
    logic therm;
    logic [1:0] reg_en;
    pin_drv_t drv;
    pin_route_t route;
  } state_t;

  localparam state_t STATE_RST = '0;

endpackage

/* File: verilog/safety_monitor_pin_config.sv */
// Supervisory core: thermal shutdown, pin function decode, voltage monitor flags
`timescale 1ns/100ps
module safety_monitor_pin_config (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Programmed settings, read once after reset
  input wire logic [2:0] addr_sel_in,
  input wire logic [1:0] pin1_function_sel_in,
  input wire logic [1:0] pin2_function_sel_in,
  input wire logic [1:0] pin3_function_sel_in,
  input wire safety_pkg::mon_cfg_t [3:0] mon_cfg_in,
  // Comparators
  input wire logic over_temp_in,
  input wire logic [3:0] uv_cmp_in,
  input wire logic [3:0] ov_cmp_in,
  // Software controls
  input wire logic [1:0] regulator_enable_in,
  input wire logic [2:0] general_output_in,
  input wire logic thermal_clear_in,
  input wire logic [3:0] uv_clear_in,
  input wire logic [3:0] ov_clear_in,
  // Pins
  input wire logic [2:0] pin_in,
  input wire logic sync_clk_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_out,
  output safety_pkg::pin_route_t pin_route_out,
  // Status
  output logic [6:0] slave_addr_out,
  output safety_pkg::mon_cfg_t [3:0] mon_cfg_out,
  output logic thermal_shutdown_out,
  output logic thermal_event_latch_out,
  output logic [1:0] regulator_en_out,
  output logic [3:0] undervolt_live_status_out,
  output logic [3:0] overvolt_live_status_out,
  output logic [3:0] undervolt_latched_flag_out,
  output logic [3:0] overvolt_latched_flag_out,
  output logic [3:0] monitor_fault_out
);
  import safety_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Counts microsecond ticks while raw stays high; any drop restarts it
  function automatic dbn_t dbn_step(input logic raw, input logic tick, input dbn_t cur,
                                    input logic [6:0] lim);
    dbn_t r;
    r = cur;
    if (!raw)
      r = '0;
    else if (!cur.hit && tick)
    begin
      r.cnt = cur.cnt + 7'h1;
      r.hit = (r.cnt >= lim);
    end
    return r;
  endfunction

  function automatic logic [6:0] uv_limit(input logic [1:0] sel);
    return 7'(UV_DB_US[sel] / TICK_US);
  endfunction

  function automatic logic [6:0] ov_limit(input logic [1:0] sel);
    return 7'(OV_DB_US[sel] / TICK_US);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  state_t s_ff;
  state_t nxt_s;
  logic tick;
  logic shut;
  logic enter_shut;
  logic mon_en [4];
  logic [1:0] sel1;
  logic [1:0] sel2;
  logic [1:0] sel3;

  always_comb
  begin
    nxt_s = s_ff;
    tick = (s_ff.div == TICK_LAST);
    nxt_s.div = tick ? 7'h0 : s_ff.div + 7'h1;
    case (s_ff.mode)
      ST_CAPTURE:
      begin
        // Settings are sampled once; later changes on these inputs are ignored
        nxt_s.pin_sel = {pin3_function_sel_in, pin2_function_sel_in, pin1_function_sel_in};
        nxt_s.cfg = mon_cfg_in;
        // Only a slave address is produced; this core never starts a transfer
        nxt_s.slave_addr = ADDR_BASE + {4'h0, addr_sel_in};
        nxt_s.mode = ST_RUN;
      end
      ST_RUN, ST_SHUTDOWN:
        nxt_s.mode = s_ff.mode;
      default:
        nxt_s.mode = ST_CAPTURE;
    endcase

    nxt_s.over_temp_db = dbn_step(over_temp_in, tick, s_ff.over_temp_db, THERM_TICKS);
    enter_shut = (s_ff.mode == ST_RUN) && nxt_s.over_temp_db.hit;
    if (enter_shut)
      nxt_s.mode = ST_SHUTDOWN;
    // Set wins over a clear in the same cycle
    nxt_s.therm = (s_ff.therm & ~thermal_clear_in) | enter_shut;

    sel1 = nxt_s.pin_sel[1:0];
    sel2 = nxt_s.pin_sel[3:2];
    sel3 = nxt_s.pin_sel[5:4];
    // Monitors 3 and 4 share pins and only run when the pin is given to them
    mon_en[0] = 1'b1;
    mon_en[1] = 1'b1;
    mon_en[2] = (sel2 == P2_VMON);
    mon_en[3] = (sel3 == P3_VMON);
    for (int i = 0; i < MON_N; i++)
    begin
      nxt_s.uv_db[i] = dbn_step(mon_en[i] & uv_cmp_in[i], tick, s_ff.uv_db[i],
                                uv_limit(s_ff.cfg[i].fault_debounce_sel));
      nxt_s.ov_db[i] = dbn_step(mon_en[i] & ov_cmp_in[i], tick, s_ff.ov_db[i],
                                ov_limit(s_ff.cfg[i].overvolt_debounce_sel));
      nxt_s.live.uv[i] = nxt_s.uv_db[i].hit;
      nxt_s.live.ov[i] = nxt_s.ov_db[i].hit;
      nxt_s.flag.uv[i] = (s_ff.flag.uv[i] & ~uv_clear_in[i]) | nxt_s.uv_db[i].hit;
      nxt_s.flag.ov[i] = (s_ff.flag.ov[i] & ~ov_clear_in[i]) | nxt_s.ov_db[i].hit;
      nxt_s.fault[i] = nxt_s.live.uv[i] | nxt_s.live.ov[i];
    end

    // Rails and outputs drop in the same cycle as the shutdown state, no sequence
    shut = (nxt_s.mode == ST_SHUTDOWN);
    nxt_s.reg_en = shut ? 2'b00 : regulator_enable_in;

    // General outputs are open-drain: enable pulls the pin low
    nxt_s.drv = '0;
    if (sel1 == P1_OUT)
      nxt_s.drv.oe[0] = ~general_output_in[0] | shut;
    case (sel2)
      P2_OUT:
        nxt_s.drv.oe[1] = ~general_output_in[1] | shut;
      P2_SYNC:
      begin
        nxt_s.drv.oe[1] = 1'b1;
        nxt_s.drv.out[1] = sync_clk_in & ~shut;
      end
      default:
        nxt_s.drv.oe[1] = 1'b0;
    endcase
    if (sel3 == P3_OUT)
      nxt_s.drv.oe[2] = ~general_output_in[2] | shut;

    nxt_s.route.error_monitor_in1 = (sel1 == P1_ERR) & pin_in[0];
    nxt_s.route.fault_collect_in1 = (sel2 == P2_FLT) & pin_in[1];
    nxt_s.route.volt_monitor_in3 = (sel2 == P2_VMON);
    nxt_s.route.fault_collect_in2 = (sel3 == P3_FLT) & pin_in[2];
    nxt_s.route.error_monitor_in2 = (sel3 == P3_ERR) & pin_in[2];
    nxt_s.route.volt_monitor_in4 = (sel3 == P3_VMON);
  end

  // Shutdown is left only through reset, which stands for a full power cycle
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      s_ff <= STATE_RST;
    else
      s_ff <= nxt_s;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pin_out = s_ff.drv.out;
  assign pin_oe_out = s_ff.drv.oe;
  assign pin_route_out = s_ff.route;
  assign slave_addr_out = s_ff.slave_addr;
  assign mon_cfg_out = s_ff.cfg;
  assign thermal_shutdown_out = (s_ff.mode == ST_SHUTDOWN);
  assign thermal_event_latch_out = s_ff.therm;
  assign regulator_en_out = s_ff.reg_en;
  assign undervolt_live_status_out = s_ff.live.uv;
  assign overvolt_live_status_out = s_ff.live.ov;
  assign undervolt_latched_flag_out = s_ff.flag.uv;
  assign overvolt_latched_flag_out = s_ff.flag.ov;
  assign monitor_fault_out = s_ff.fault;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence uv0_clear_while_live;
    uv_clear_in[0] && undervolt_live_status_out[0] && uv_cmp_in[0];
  endsequence

  sequence uv0_clear_idle;
    uv_clear_in[0] && !uv_cmp_in[0];
  endsequence

  a_addr_value: assert property ((s_ff.mode != ST_CAPTURE) |->
    slave_addr_out == ADDR_BASE + {4'h0, $past(addr_sel_in, 1)} || $stable(slave_addr_out))
    else $error("slave address wrong");

  a_therm_debounce: assert property ($rose(thermal_shutdown_out) |->
    s_ff.over_temp_db.cnt == THERM_TICKS && $past(over_temp_in))
    else $error("shutdown before debounce ended");

  a_therm_latch: assert property ($rose(thermal_shutdown_out) |-> thermal_event_latch_out)
    else $error("thermal flag not set");

  a_therm_rails: assert property (thermal_shutdown_out |->
    regulator_en_out == 2'b00 && pin_out == 3'h0 &&
    (s_ff.pin_sel[1:0] != P1_OUT || pin_oe_out[0]))
    else $error("rails or outputs alive in shutdown");

  a_pin_fixed: assert property ((s_ff.mode != ST_CAPTURE) |=> $stable(s_ff.pin_sel))
    else $error("pin function changed after start");

  a_pin1_hiz: assert property ((s_ff.mode == ST_RUN && s_ff.pin_sel[1:0] == P1_HIZ) |=>
    !pin_oe_out[0])
    else $error("pin 1 driven in hi-z mode");

  a_pin2_sync: assert property ((s_ff.mode == ST_RUN && s_ff.pin_sel[3:2] == P2_SYNC &&
    !over_temp_in) |=> pin_oe_out[1] && pin_out[1] == $past(sync_clk_in))
    else $error("sync output not following clock");

  a_pin3_route: assert property ((s_ff.pin_sel[5:4] == P3_ERR && s_ff.mode != ST_CAPTURE) |=>
    pin_route_out.error_monitor_in2 == $past(pin_in[2]) && !pin_oe_out[2])
    else $error("pin 3 error input not routed");

  a_cfg_pass: assert property ($rose(s_ff.mode == ST_RUN) |-> mon_cfg_out == $past(mon_cfg_in))
    else $error("thresholds not passed on");

  a_uv_debounce: assert property ($rose(undervolt_live_status_out[0]) |->
    s_ff.uv_db[0].cnt == uv_limit(s_ff.cfg[0].fault_debounce_sel))
    else $error("undervolt declared at wrong count");

  a_flag_clear: assert property (uv0_clear_idle |=> !undervolt_latched_flag_out[0])
    else $error("write one did not clear flag");

  a_flag_keep: assert property ((undervolt_latched_flag_out[0] && !uv_clear_in[0]) |=>
    undervolt_latched_flag_out[0])
    else $error("flag lost without clear");

  a_live_restart: assert property (!ov_cmp_in[1] |=>
    !overvolt_live_status_out[1] && s_ff.ov_db[1].cnt == 7'h0)
    else $error("debounce not restarted");

  a_fault_route: assert property (monitor_fault_out ==
    (undervolt_live_status_out | overvolt_live_status_out))
    else $error("fault route disagrees with status");

  a_clear_live: assert property (uv0_clear_while_live |=> undervolt_latched_flag_out[0])
    else $error("flag cleared while fault present");

endmodule

/* File: sim/pin_world.sv */
// Board-side model of the three multipurpose pins with their pull-ups
`timescale 1ns/100ps
module pin_world (
  // Design pin drive
  input wire logic [2:0] pin_out_in,
  input wire logic [2:0] pin_oe_in,
  // External drivers on the board
  input wire logic [2:0] ext_en_in,
  input wire logic [2:0] ext_val_in,
  // Resolved pin level
  output logic [2:0] pin_level_out
);
  // Undriven pins read high through the pull-up, never a stale value
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (pin_oe_in[i])
        pin_level_out[i] = pin_out_in[i];
      else if (ext_en_in[i])
        pin_level_out[i] = ext_val_in[i];
      else
        pin_level_out[i] = 1'b1;
    end
  end
endmodule

/* File: sim/safety_monitor_pin_config_tb_top.sv */
// Self-checking bench for the supervisory safety core
`timescale 1ns/100ps
module safety_monitor_pin_config_tb_top;
  import safety_pkg::*;
  logic mclk_in = 0;
  logic rst_in = 1;
  logic [2:0] addr_sel = '0, gen_out = '0, ext_val = '0, ext_en = '0, pin_in, pin_out, pin_oe;
  logic [1:0] p1 = '0, p2 = '0, p3 = '0, reg_en_in = '0, reg_en;
  mon_cfg_t [3:0] cfg = '0, cfg_out;
  logic ot = 0, tclr = 0, sync = 0, shut_seen, tlatch;
  logic [3:0] uvc = '0, ovc = '0, uvclr = '0, ovclr = '0, uvl, ovl, uvf, ovf, mfault;
  logic [6:0] saddr;
  pin_route_t route;
  int err_total = 0;
  int checks_done = 0;

  always #4 mclk_in = ~mclk_in;

  safety_monitor_pin_config i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .addr_sel_in(addr_sel), .pin1_function_sel_in(p1), .pin2_function_sel_in(p2),
    .pin3_function_sel_in(p3), .mon_cfg_in(cfg), .over_temp_in(ot), .uv_cmp_in(uvc),
    .ov_cmp_in(ovc), .regulator_enable_in(reg_en_in), .general_output_in(gen_out),
    .thermal_clear_in(tclr), .uv_clear_in(uvclr), .ov_clear_in(ovclr), .pin_in(pin_in),
    .sync_clk_in(sync), .pin_out(pin_out), .pin_oe_out(pin_oe), .pin_route_out(route),
    .slave_addr_out(saddr), .mon_cfg_out(cfg_out), .thermal_shutdown_out(shut_seen),
    .thermal_event_latch_out(tlatch), .regulator_en_out(reg_en),
    .undervolt_live_status_out(uvl), .overvolt_live_status_out(ovl),
    .undervolt_latched_flag_out(uvf), .overvolt_latched_flag_out(ovf),
    .monitor_fault_out(mfault));

  pin_world i_pins (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pin_level_out(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic int db_us(input bit ov, input logic [1:0] s);
    int uv_t[4] = '{5, 15, 30, 40};
    int ov_t[4] = '{30, 50, 80, 125};
    return ov ? ov_t[s] : uv_t[s];
  endfunction

  function automatic logic bitsel(input logic [3:0] u, o, input bit ov, input int i);
    return ov ? o[i] : u[i];
  endfunction

  // Settings must be steady at the first edge after release
  task automatic boot(input logic [1:0] a, b, c);
    rst_in = 1;
    p1 = a;
    p2 = b;
    p3 = c;
    addr_sel = 3'($urandom);
    cfg = 48'({$urandom, $urandom});
    tick(5);
    rst_in = 0;
    tick(3);
  endtask

  task automatic set_cmp(input bit th, ov, input int i, input logic v);
    if (th)
      ot = v;
    else if (ov)
      ovc[i] = v;
    else
      uvc[i] = v;
  endtask

  task automatic pulse_clr(input bit ov, input int i);
    if (ov)
      ovclr[i] = 1;
    else
      uvclr[i] = 1;
    tick(1);
    ovclr = '0;
    uvclr = '0;
  endtask

  // Tick resolution allows the status up to one microsecond early
  task automatic expect_rise(input bit th, ov, input int i, n);
    int c;
    c = 0;
    set_cmp(th, ov, i, 1);
    do
    begin
      tick(1);
      c++;
    end
    while (!(th ? shut_seen : bitsel(uvl, ovl, ov, i)) && c < n * 125 + 20);
    chk("debounce delay", c >= (n - 1) * 125 + 1 && c <= n * 125 + 1, 1);
  endtask

  task automatic mon_test(input int i, input bit ov);
    int n;
    n = db_us(ov, ov ? cfg[i].overvolt_debounce_sel : cfg[i].fault_debounce_sel);
    expect_rise(0, ov, i, n);
    chk("latched flag", bitsel(uvf, ovf, ov, i), 1);
    chk("monitor fault", mfault[i], 1);
    pulse_clr(ov, i);
    chk("flag under fault", bitsel(uvf, ovf, ov, i), 1);
    set_cmp(0, ov, i, 0);
    tick(1);
    chk("live status", bitsel(uvl, ovl, ov, i), 0);
    tick(3);
    chk("flag held", bitsel(uvf, ovf, ov, i), 1);
    pulse_clr(ov, i);
    chk("flag cleared", bitsel(uvf, ovf, ov, i), 0);
    $display("test monitor %0d done", i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    gen_out = 3'($urandom(90952));
    for (int k = 0; k < 4; k++)
    begin
      boot(2'(k), 2'(k), 2'(k));
      chk("slave address", saddr, 7'h18 + addr_sel);
      chk("thresholds", cfg_out, cfg);
      // Later changes of the settings must be ignored
      p1 = ~p1;
      p2 = ~p2;
      p3 = ~p3;
      for (int j = 0; j < 2; j++)
      begin
        gen_out = 3'($urandom);
        sync = 1'($urandom);
        ext_val = 3'($urandom);
        ext_en = 3'b111;
        reg_en_in = 2'($urandom);
        tick(2);
        chk("regulators", reg_en, reg_en_in);
        chk("pin oe", pin_oe, {k == 0 ? ~gen_out[2] : 1'b0, k == 0 ? ~gen_out[1] : (k == 2),
          k == 1 ? ~gen_out[0] : 1'b0});
        chk("pin out", pin_out, {1'b0, k == 2 ? sync : 1'b0, 1'b0});
        chk("pin route", route, {k == 2 && ext_val[0], k == 2 && ext_val[2],
          k == 1 && ext_val[1], k == 1 && ext_val[2], k == 3, k == 3});
      end
      $display("test pins %0d done", k);
    end
    boot(1, 3, 3);
    ext_en = '0;
    // Glitch part way through must restart the count
    set_cmp(0, 0, 0, 1);
    tick(db_us(0, cfg[0].fault_debounce_sel) * 125 - 130);
    set_cmp(0, 0, 0, 0);
    tick(1);
    for (int i = 0; i < 4; i++)
      mon_test(i, i[0]);
    reg_en_in = 2'b11;
    gen_out = 3'($urandom);
    tick(2);
    chk("regulators on", reg_en, 2'b11);
    expect_rise(1, 0, 0, 100);
    chk("event latch", tlatch, 1);
    chk("regulators off", reg_en, 2'b00);
    chk("pin1 low", {pin_oe[0], pin_out[0]}, 2'b10);
    ot = 0;
    tick(10);
    chk("shutdown held", {shut_seen, tlatch}, 2'b11);
    tclr = 1;
    tick(1);
    tclr = 0;
    chk("latch cleared", tlatch, 0);
    $display("test thermal done");
    test_done();
  end

  initial
  begin
    // Worst case run is about 60k cycles; give up at 90k
    #720_000;
    err_total++;
    test_done();
  end
endmodule
